// File: cpg_dev.sv
// Clock block end: gating bits, five ratio dividers and two source selects.
`timescale 1ns/1ns
`default_nettype none
`include "cpg_regs.svh"
module cpg_dev
(
  input wire logic clk,
  input wire logic resetn,
  cpg_bus_if.dev bus,
  input wire logic mainTick,
  input wire logic rcTick,
  input wire logic sysOscTick,
  input wire logic wdOscTick,
  output logic canClkOn,
  output logic spi1ClkOn,
  output logic spi0Tick,
  output logic uartTick,
  output logic spi1Tick,
  output logic wdtTick,
  output logic clkOutTick
);
  localparam int NDIV = `CPG_DIV_COUNT;

  logic canGate_q;
  logic spi1Gate_q;
  logic [7:0] ratio_q [NDIV];
  logic [7:0] cnt_q [NDIV];
  logic [NDIV-1:0] tick_q;
  logic [NDIV-1:0] srcTick;
  logic [NDIV-1:0] restart;
  logic [1:0] wdtChoice_q;
  logic [1:0] outChoice_q;
  logic wdtApply_q;
  logic outApply_q;
  logic wdtApplyPrev_q;
  logic outApplyPrev_q;
  cpg_pkg::cpg_wdt_src_t wdtAct_q;
  cpg_pkg::cpg_out_src_t outAct_q;
  logic wdtRise;
  logic outRise;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // One divider step: returns the output pulse and the next count.
  function automatic logic [8:0] cpgDivStep
  (
    input logic [7:0] cnt,
    input logic [7:0] ratio,
    input logic src
  );
    logic [8:0] res;
    res = {1'b0, cnt};
    if (ratio == 8'h00)
      res = 9'h000;
    else if (src && cnt >= 8'(ratio - 8'h01))
      res = 9'h100;
    else if (src)
      res = {1'b0, 8'(cnt + 8'h01)};
    return res;
  endfunction : cpgDivStep

  // Returns true when the bus address equals the given address.
  function automatic logic cpgHit
  (
    input logic [31:0] a,
    input logic [31:0] target
  );
    return a == target;
  endfunction : cpgHit

  // Gating bits; only bits 17 and 18 are stored.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      canGate_q <= `CPG_GATE_RESET;
      spi1Gate_q <= `CPG_GATE_RESET;
    end
    else if (bus.wr && cpgHit(bus.addr, `CPG_ADDR_GATE))
    begin
      canGate_q <= bus.wdata[`CPG_GATE_CAN_BIT];
      spi1Gate_q <= bus.wdata[`CPG_GATE_SPI1_BIT];
    end
  end

  // Ratio fields of the five dividers; upper bits are dropped.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NDIV; i++)
        ratio_q[i] <= `CPG_RATIO_RESET;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        `CPG_ADDR_SPI0_RATIO: ratio_q[`CPG_DIV_SPI0] <= bus.wdata[7:0];
        `CPG_ADDR_UART_RATIO: ratio_q[`CPG_DIV_UART] <= bus.wdata[7:0];
        `CPG_ADDR_SPI1_RATIO: ratio_q[`CPG_DIV_SPI1] <= bus.wdata[7:0];
        `CPG_ADDR_WDT_RATIO: ratio_q[`CPG_DIV_WDT] <= bus.wdata[7:0];
        `CPG_ADDR_OUT_RATIO: ratio_q[`CPG_DIV_OUT] <= bus.wdata[7:0];
        default: ratio_q[`CPG_DIV_SPI0] <= ratio_q[`CPG_DIV_SPI0];
      endcase
    end
  end

  // Source choices and apply bits as software wrote them.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdtChoice_q <= `CPG_SEL_RESET;
      outChoice_q <= `CPG_SEL_RESET;
      wdtApply_q <= `CPG_APPLY_RESET;
      outApply_q <= `CPG_APPLY_RESET;
    end
    else if (bus.wr)
    begin
      if (cpgHit(bus.addr, `CPG_ADDR_WDT_CHOICE))
        wdtChoice_q <= bus.wdata[1:0];
      if (cpgHit(bus.addr, `CPG_ADDR_OUT_CHOICE))
        outChoice_q <= bus.wdata[1:0];
      if (cpgHit(bus.addr, `CPG_ADDR_WDT_APPLY))
        wdtApply_q <= bus.wdata[`CPG_APPLY_BIT];
      if (cpgHit(bus.addr, `CPG_ADDR_OUT_APPLY))
        outApply_q <= bus.wdata[`CPG_APPLY_BIT];
    end
  end

  // Previous apply bits, for rising-edge detection.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdtApplyPrev_q <= `CPG_APPLY_RESET;
      outApplyPrev_q <= `CPG_APPLY_RESET;
    end
    else
    begin
      wdtApplyPrev_q <= wdtApply_q;
      outApplyPrev_q <= outApply_q;
    end
  end

  // A stored apply bit going from zero to one commits the choice.
  assign wdtRise = wdtApply_q && !wdtApplyPrev_q;
  assign outRise = outApply_q && !outApplyPrev_q;

  // Active sources only change on an apply rise.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdtAct_q <= cpg_pkg::WDT_SRC_RC;
      outAct_q <= cpg_pkg::OUT_SRC_RC;
    end
    else
    begin
      if (wdtRise)
        wdtAct_q <= cpg_pkg::cpg_wdt_src_t'(wdtChoice_q);
      if (outRise)
        outAct_q <= cpg_pkg::cpg_out_src_t'(outChoice_q);
    end
  end

  // Source pulse for each divider; the reserved watchdog code gives none.
  always_comb
  begin
    srcTick = '0;
    srcTick[`CPG_DIV_SPI0] = mainTick;
    srcTick[`CPG_DIV_UART] = mainTick;
    srcTick[`CPG_DIV_SPI1] = mainTick;
    case (wdtAct_q)
      cpg_pkg::WDT_SRC_RC: srcTick[`CPG_DIV_WDT] = rcTick;
      cpg_pkg::WDT_SRC_MAIN: srcTick[`CPG_DIV_WDT] = mainTick;
      cpg_pkg::WDT_SRC_WDOSC: srcTick[`CPG_DIV_WDT] = wdOscTick;
      default: srcTick[`CPG_DIV_WDT] = 1'b0;
    endcase
    case (outAct_q)
      cpg_pkg::OUT_SRC_RC: srcTick[`CPG_DIV_OUT] = rcTick;
      cpg_pkg::OUT_SRC_SYSOSC: srcTick[`CPG_DIV_OUT] = sysOscTick;
      cpg_pkg::OUT_SRC_WDOSC: srcTick[`CPG_DIV_OUT] = wdOscTick;
      default: srcTick[`CPG_DIV_OUT] = mainTick;
    endcase
    restart = '0;
    restart[`CPG_DIV_WDT] = wdtRise;
    restart[`CPG_DIV_OUT] = outRise;
  end

  // Dividers; a switch clears the count so the next period is whole.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NDIV; i++)
        cnt_q[i] <= 8'h00;
      tick_q <= '0;
    end
    else
    begin
      for (int i = 0; i < NDIV; i++)
      begin
        if (restart[i])
        begin
          cnt_q[i] <= 8'h00;
          tick_q[i] <= 1'b0;
        end
        else
        begin
          cnt_q[i] <= cpgDivStep(cnt_q[i], ratio_q[i], srcTick[i])[7:0];
          tick_q[i] <= cpgDivStep(cnt_q[i], ratio_q[i], srcTick[i])[8];
        end
      end
    end
  end

  // Read mux; unstored and reserved bits return zero.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (bus.addr)
      `CPG_ADDR_GATE:
      begin
        rdata_d[`CPG_GATE_CAN_BIT] = canGate_q;
        rdata_d[`CPG_GATE_SPI1_BIT] = spi1Gate_q;
      end
      `CPG_ADDR_SPI0_RATIO: rdata_d[7:0] = ratio_q[`CPG_DIV_SPI0];
      `CPG_ADDR_UART_RATIO: rdata_d[7:0] = ratio_q[`CPG_DIV_UART];
      `CPG_ADDR_SPI1_RATIO: rdata_d[7:0] = ratio_q[`CPG_DIV_SPI1];
      `CPG_ADDR_WDT_CHOICE: rdata_d[1:0] = wdtChoice_q;
      `CPG_ADDR_WDT_APPLY: rdata_d[0] = wdtApply_q;
      `CPG_ADDR_WDT_RATIO: rdata_d[7:0] = ratio_q[`CPG_DIV_WDT];
      `CPG_ADDR_OUT_CHOICE: rdata_d[1:0] = outChoice_q;
      `CPG_ADDR_OUT_APPLY: rdata_d[0] = outApply_q;
      `CPG_ADDR_OUT_RATIO: rdata_d[7:0] = ratio_q[`CPG_DIV_OUT];
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h0000_0000;
    else if (bus.rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 32'h0000_0000;
  end

  // Outputs, all from flip-flops.
  assign bus.rdata = rdata_q;
  assign canClkOn = canGate_q;
  assign spi1ClkOn = spi1Gate_q;
  assign spi0Tick = tick_q[`CPG_DIV_SPI0];
  assign uartTick = tick_q[`CPG_DIV_UART];
  assign spi1Tick = tick_q[`CPG_DIV_SPI1];
  assign wdtTick = tick_q[`CPG_DIV_WDT];
  assign clkOutTick = tick_q[`CPG_DIV_OUT];
endmodule : cpg_dev
`default_nettype wire

// File: cpg_regs.svh
// Register addresses, field positions, reset values and codes of the peripheral clock block.
`ifndef CPG_REGS_SVH
`define CPG_REGS_SVH

`define CPG_ADDR_GATE 32'h4004_8080
`define CPG_ADDR_SPI0_RATIO 32'h4004_8094
`define CPG_ADDR_UART_RATIO 32'h4004_8098
`define CPG_ADDR_SPI1_RATIO 32'h4004_809C
`define CPG_ADDR_WDT_CHOICE 32'h4004_80D0
`define CPG_ADDR_WDT_APPLY 32'h4004_80D4
`define CPG_ADDR_WDT_RATIO 32'h4004_80D8
`define CPG_ADDR_OUT_CHOICE 32'h4004_80E0
`define CPG_ADDR_OUT_APPLY 32'h4004_80E4
`define CPG_ADDR_OUT_RATIO 32'h4004_80E8

`define CPG_GATE_CAN_BIT 17
`define CPG_GATE_SPI1_BIT 18
`define CPG_RATIO_MSB 7
`define CPG_SEL_MSB 1
`define CPG_APPLY_BIT 0

`define CPG_GATE_RESET 1'b0
`define CPG_RATIO_RESET 8'h00
`define CPG_SEL_RESET 2'h0
`define CPG_APPLY_RESET 1'b0

`define CPG_DIV_COUNT 5
`define CPG_DIV_SPI0 0
`define CPG_DIV_UART 1
`define CPG_DIV_SPI1 2
`define CPG_DIV_WDT 3
`define CPG_DIV_OUT 4

`define CPG_CTL_ADDR 5'h00
`define CPG_CTL_DATA 5'h04
`define CPG_CTL_GO 5'h08
`define CPG_CTL_STATUS 5'h0C
`define CPG_CTL_RDATA 5'h10
`define CPG_GO_WRITE 0
`define CPG_GO_READ 1
`define CPG_GO_WDT_APPLY 2
`define CPG_GO_OUT_APPLY 3
`define CPG_STAT_REFUSED 0
`define CPG_STAT_BUSY 1

`endif

// File: cpg_pkg.sv
// Types shared by both ends of the peripheral clock block.
package cpg_pkg;

  typedef enum logic [1:0]
  {
    WDT_SRC_RC = 2'h0,
    WDT_SRC_MAIN = 2'h1,
    WDT_SRC_WDOSC = 2'h2,
    WDT_SRC_RSVD = 2'h3
  } cpg_wdt_src_t;

  typedef enum logic [1:0]
  {
    OUT_SRC_RC = 2'h0,
    OUT_SRC_SYSOSC = 2'h1,
    OUT_SRC_WDOSC = 2'h2,
    OUT_SRC_MAIN = 2'h3
  } cpg_out_src_t;

  typedef enum logic [2:0]
  {
    CTL_IDLE = 3'h0,
    CTL_WRITE = 3'h1,
    CTL_READ = 3'h3,
    CTL_CAPT = 3'h2,
    CTL_WAITSRC = 3'h6,
    CTL_CLEAR = 3'h7,
    CTL_SET = 3'h5
  } cpg_ctl_state_t;

endpackage : cpg_pkg

// File: cpg_bus_if.sv
// Register port between the controller end and the clock block end.
`timescale 1ns/1ns
`default_nettype none
interface cpg_bus_if
(
  input wire logic clk,
  input wire logic resetn
);
  logic [31:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;

  modport dev (input clk, input resetn, input addr, input wdata, input wr, input rd, output rdata);
  modport ctl (input clk, input resetn, output addr, output wdata, output wr, output rd,
    input rdata);
endinterface : cpg_bus_if
`default_nettype wire

// File: cpg_ctl.sv
// Controller end: turns software orders into register accesses on the clock block.
`timescale 1ns/1ns
`default_nettype none
`include "cpg_regs.svh"
module cpg_ctl
(
  input wire logic clk,
  input wire logic resetn,
  cpg_bus_if.ctl bus,
  input wire logic [4:0] ctlAddr,
  input wire logic [31:0] ctlWdata,
  input wire logic ctlWr,
  input wire logic ctlRd,
  output logic [31:0] ctlRdata,
  input wire logic uartPinsReady,
  input wire logic bothSrcRunning
);
  cpg_pkg::cpg_ctl_state_t state_q;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic [31:0] rdata_q;
  logic [31:0] applyAddr_q;
  logic refused_q;
  logic [31:0] ctlRdata_q;
  logic goWr;
  logic uartBlock;

  // A go command is only taken while idle.
  assign goWr = ctlWr && (ctlAddr == `CPG_CTL_GO) && (state_q == cpg_pkg::CTL_IDLE);
  // A nonzero uart ratio before the pins are set up is refused.
  assign uartBlock = (addr_q == `CPG_ADDR_UART_RATIO) && (data_q[7:0] != 8'h00)
    && !uartPinsReady;

  // Bus strobes follow the state; address and data come from flip-flops.
  assign bus.wr = (state_q == cpg_pkg::CTL_WRITE) || (state_q == cpg_pkg::CTL_CLEAR)
    || (state_q == cpg_pkg::CTL_SET);
  assign bus.rd = (state_q == cpg_pkg::CTL_READ);
  assign bus.addr = (state_q == cpg_pkg::CTL_CLEAR || state_q == cpg_pkg::CTL_SET)
    ? applyAddr_q : addr_q;
  assign bus.wdata = (state_q == cpg_pkg::CTL_CLEAR) ? 32'h0000_0000
    : (state_q == cpg_pkg::CTL_SET) ? 32'h0000_0001 : data_q;
  assign ctlRdata = ctlRdata_q;

  // Sequencer for single accesses and the apply handshake.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= cpg_pkg::CTL_IDLE;
      applyAddr_q <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        cpg_pkg::CTL_IDLE:
        begin
          if (goWr && ctlWdata[`CPG_GO_WRITE] && !uartBlock)
            state_q <= cpg_pkg::CTL_WRITE;
          else if (goWr && ctlWdata[`CPG_GO_READ])
            state_q <= cpg_pkg::CTL_READ;
          else if (goWr && (ctlWdata[`CPG_GO_WDT_APPLY] || ctlWdata[`CPG_GO_OUT_APPLY]))
          begin
            state_q <= cpg_pkg::CTL_WAITSRC;
            applyAddr_q <= ctlWdata[`CPG_GO_WDT_APPLY] ? `CPG_ADDR_WDT_APPLY
              : `CPG_ADDR_OUT_APPLY;
          end
        end
        cpg_pkg::CTL_WRITE: state_q <= cpg_pkg::CTL_IDLE;
        cpg_pkg::CTL_READ: state_q <= cpg_pkg::CTL_CAPT;
        cpg_pkg::CTL_CAPT: state_q <= cpg_pkg::CTL_IDLE;
        // Hold the update until old and new sources both run.
        cpg_pkg::CTL_WAITSRC: if (bothSrcRunning) state_q <= cpg_pkg::CTL_CLEAR;
        // Write zero then one so the apply bit rises.
        cpg_pkg::CTL_CLEAR: state_q <= cpg_pkg::CTL_SET;
        cpg_pkg::CTL_SET: state_q <= cpg_pkg::CTL_IDLE;
        default: state_q <= cpg_pkg::CTL_IDLE;
      endcase
    end
  end

  // Software-written address and data registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_q <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
    end
    else if (ctlWr && ctlAddr == `CPG_CTL_ADDR)
      addr_q <= ctlWdata;
    else if (ctlWr && ctlAddr == `CPG_CTL_DATA)
      data_q <= ctlWdata;
  end

  // Refused flag: a refusal in the clearing cycle wins.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      refused_q <= 1'b0;
    else if (goWr && ctlWdata[`CPG_GO_WRITE] && uartBlock)
      refused_q <= 1'b1;
    else if (ctlWr && ctlAddr == `CPG_CTL_STATUS && ctlWdata[`CPG_STAT_REFUSED])
      refused_q <= 1'b0;
  end

  // Capture of bus read data one cycle after the read strobe.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h0000_0000;
    else if (state_q == cpg_pkg::CTL_CAPT)
      rdata_q <= bus.rdata;
  end

  // Software read port, data in the cycle after the strobe.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctlRdata_q <= 32'h0000_0000;
    else if (ctlRd)
    begin
      case (ctlAddr)
        `CPG_CTL_ADDR: ctlRdata_q <= addr_q;
        `CPG_CTL_DATA: ctlRdata_q <= data_q;
        `CPG_CTL_STATUS: ctlRdata_q <= {30'h0, state_q != cpg_pkg::CTL_IDLE, refused_q};
        `CPG_CTL_RDATA: ctlRdata_q <= rdata_q;
        default: ctlRdata_q <= 32'h0000_0000;
      endcase
    end
    else
      ctlRdata_q <= 32'h0000_0000;
  end
endmodule : cpg_ctl
`default_nettype wire

// File: cpg_bus_chk.sv
// Protocol and reserved-bit checks on the register port between the two ends.
`timescale 1ns/1ns
`default_nettype none
`include "cpg_regs.svh"
module cpg_bus_chk
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Strobes stay apart and read data only shows in the cycle after a read.
  a_strobes_apart: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  // An apply write of zero is followed at once by a write of one.
  a_wdt_apply_pair: assert property (wr && addr == `CPG_ADDR_WDT_APPLY && !wdata[0] |=>
    wr && addr == `CPG_ADDR_WDT_APPLY && wdata[0])
    else $error("watchdog apply not written zero then one");
  a_out_apply_pair: assert property (wr && addr == `CPG_ADDR_OUT_APPLY && !wdata[0] |=>
    wr && addr == `CPG_ADDR_OUT_APPLY && wdata[0])
    else $error("output apply not written zero then one");
  // Reserved bits always read back as zero.
  a_gate_rsvd: assert property (rd && addr == `CPG_ADDR_GATE |=>
    rdata[31:19] == 13'h0 && rdata[16:0] == 17'h0)
    else $error("gate register reserved bits set");
  a_ratio_rsvd: assert property (rd && (addr == `CPG_ADDR_SPI0_RATIO ||
    addr == `CPG_ADDR_UART_RATIO || addr == `CPG_ADDR_SPI1_RATIO ||
    addr == `CPG_ADDR_WDT_RATIO || addr == `CPG_ADDR_OUT_RATIO) |=> rdata[31:8] == 24'h0)
    else $error("ratio reserved bits set");
  a_choice_rsvd: assert property (rd && (addr == `CPG_ADDR_WDT_CHOICE ||
    addr == `CPG_ADDR_OUT_CHOICE) |=> rdata[31:2] == 30'h0)
    else $error("choice reserved bits set");
  a_apply_rsvd: assert property (rd && (addr == `CPG_ADDR_WDT_APPLY ||
    addr == `CPG_ADDR_OUT_APPLY) |=> rdata[31:1] == 31'h0)
    else $error("apply reserved bits set");
endmodule : cpg_bus_chk
`default_nettype wire

// File: tb_cpg.sv
// Self-checking testbench for the controller and clock block joined by the register port.
`timescale 1ns/1ns
`default_nettype none
`include "cpg_regs.svh"
module tb_cpg;
  logic clk;
  logic resetn;
  logic [4:0] ctlAddr;
  logic [31:0] ctlWdata;
  logic ctlWr;
  logic ctlRd;
  logic [31:0] ctlRdata;
  logic uartPinsReady;
  logic bothSrcRunning;
  logic mainTick;
  logic rcTick;
  logic sysOscTick;
  logic wdOscTick;
  logic canClkOn;
  logic spi1ClkOn;
  logic [4:0] ticks;
  logic [31:0] v;
  int p;
  int cyc;
  int n_errors;
  int comparisons;

  cpg_bus_if bus (.clk(clk), .resetn(resetn));
  cpg_ctl u_cpg_ctl (.clk(clk), .resetn(resetn), .bus(bus), .ctlAddr(ctlAddr),
    .ctlWdata(ctlWdata), .ctlWr(ctlWr), .ctlRd(ctlRd), .ctlRdata(ctlRdata),
    .uartPinsReady(uartPinsReady), .bothSrcRunning(bothSrcRunning));
  cpg_dev u_cpg_dev (.clk(clk), .resetn(resetn), .bus(bus), .mainTick(mainTick),
    .rcTick(rcTick), .sysOscTick(sysOscTick), .wdOscTick(wdOscTick), .canClkOn(canClkOn),
    .spi1ClkOn(spi1ClkOn), .spi0Tick(ticks[0]), .uartTick(ticks[1]), .spi1Tick(ticks[2]),
    .wdtTick(ticks[3]), .clkOutTick(ticks[4]));
  cpg_bus_chk u_cpg_bus_chk (.clk(clk), .resetn(resetn), .addr(bus.addr), .wdata(bus.wdata),
    .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));

  // Source pulses with periods of 2 (main), 3 (RC), 5 (system) and 7 (watchdog oscillator).
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      cyc <= 0;
      mainTick <= 1'b0;
      rcTick <= 1'b0;
      sysOscTick <= 1'b0;
      wdOscTick <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 1;
      mainTick <= (cyc % 2 == 0);
      rcTick <= (cyc % 3 == 0);
      sysOscTick <= (cyc % 5 == 0);
      wdOscTick <= (cyc % 7 == 0);
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk

  // One-cycle write and read on the controller port.
  task automatic cw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    ctlAddr <= a;
    ctlWdata <= d;
    ctlWr <= 1'b1;
    @(posedge clk);
    ctlWr <= 1'b0;
  endtask : cw

  task automatic cr(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    ctlAddr <= a;
    ctlRd <= 1'b1;
    @(posedge clk);
    ctlRd <= 1'b0;
    #1;
    d = ctlRdata;
  endtask : cr

  // Polls the busy flag under a bound.
  task automatic idle();
    logic [31:0] s;
    int n;
    s = 32'h2;
    n = 0;
    while (s[`CPG_STAT_BUSY] !== 1'b0)
    begin
      cr(`CPG_CTL_STATUS, s);
      n++;
      if (n > 100)
      begin
        n_errors++;
        $display("unexpected at %0t: controller stays busy", $time);
        final_report();
      end
    end
  endtask : idle

  // Device register access and source apply through the controller.
  task automatic dw(input logic [31:0] a, input logic [31:0] d);
    cw(`CPG_CTL_ADDR, a);
    cw(`CPG_CTL_DATA, d);
    cw(`CPG_CTL_GO, 32'h1 << `CPG_GO_WRITE);
    idle();
  endtask : dw

  task automatic dr(input logic [31:0] a, output logic [31:0] d);
    cw(`CPG_CTL_ADDR, a);
    cw(`CPG_CTL_GO, 32'h1 << `CPG_GO_READ);
    idle();
    cr(`CPG_CTL_RDATA, d);
  endtask : dr

  task automatic ap(input int b);
    cw(`CPG_CTL_GO, 32'h1 << b);
    idle();
  endtask : ap

  // Tick interval of one output after its next tick; zero if no tick comes.
  task automatic period(input int i, output int q);
    int n;
    n = 0;
    q = 0;
    @(posedge clk);
    #1;
    while (ticks[i] !== 1'b1 && n < 1200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (ticks[i] === 1'b1)
    begin
      q = 1;
      @(posedge clk);
      #1;
      while (ticks[i] !== 1'b1 && q < 1200)
      begin
        @(posedge clk);
        #1;
        q++;
      end
      if (ticks[i] !== 1'b1)
        q = 0;
    end
  endtask : period

  // Every register reads zero after reset, gates closed.
  task automatic t_reset();
    logic [31:0] ra [10];
    ra = '{`CPG_ADDR_GATE, `CPG_ADDR_SPI0_RATIO, `CPG_ADDR_UART_RATIO, `CPG_ADDR_SPI1_RATIO,
      `CPG_ADDR_WDT_CHOICE, `CPG_ADDR_WDT_APPLY, `CPG_ADDR_WDT_RATIO, `CPG_ADDR_OUT_CHOICE,
      `CPG_ADDR_OUT_APPLY, `CPG_ADDR_OUT_RATIO};
    foreach (ra[i])
    begin
      dr(ra[i], v);
      chk(v, 32'h0, "reset value");
    end
    chk(canClkOn, 1'b0, "CAN gate after reset");
    chk(spi1ClkOn, 1'b0, "second SPI gate after reset");
  endtask : t_reset

  // Gate bits, reserved bits and an unmapped address.
  task automatic t_gate();
    dw(`CPG_ADDR_GATE, 32'hFFFF_FFFF);
    dr(`CPG_ADDR_GATE, v);
    chk(v, 32'h0006_0000, "gate readback");
    chk(canClkOn, 1'b1, "CAN gate on");
    chk(spi1ClkOn, 1'b1, "second SPI gate on");
    dw(`CPG_ADDR_GATE, 32'h0002_0000);
    chk({canClkOn, spi1ClkOn}, 2'h2, "second SPI gate off");
    dw(32'h4004_8084, 32'hFFFF_FFFF);
    dr(32'h4004_8084, v);
    chk(v, 32'h0, "unmapped read");
  endtask : t_gate

  // Three peripheral dividers: ratio 3 and ratio 0, then the 255 boundary on the SPI0 divider.
  task automatic t_ratio();
    logic [31:0] ra [3];
    ra = '{`CPG_ADDR_SPI0_RATIO, `CPG_ADDR_UART_RATIO, `CPG_ADDR_SPI1_RATIO};
    foreach (ra[i])
    begin
      dw(ra[i], 32'hFFFF_FF03);
      dr(ra[i], v);
      chk(v, 32'h3, "ratio readback");
      period(i, p);
      chk(p, 6, "divide by 3");
      dw(ra[i], 32'h0);
      period(i, p);
      chk(p, 0, "ratio zero stops");
    end
    dw(`CPG_ADDR_SPI0_RATIO, 32'hFF);
    period(0, p);
    chk(p, 510, "divide by 255");
    dw(`CPG_ADDR_SPI0_RATIO, 32'h0);
  endtask : t_ratio

  // UART clock enable refused while its pins are not ready.
  task automatic t_uart();
    @(posedge clk);
    uartPinsReady <= 1'b0;
    dw(`CPG_ADDR_UART_RATIO, 32'h5);
    cr(`CPG_CTL_STATUS, v);
    chk(v[`CPG_STAT_REFUSED], 1'b1, "refusal flag");
    dr(`CPG_ADDR_UART_RATIO, v);
    chk(v, 32'h0, "refused ratio kept");
    cw(`CPG_CTL_STATUS, 32'h1);
    uartPinsReady <= 1'b1;
    cr(`CPG_CTL_STATUS, v);
    chk(v[`CPG_STAT_REFUSED], 1'b0, "refusal flag cleared");
  endtask : t_uart

  // Watchdog source: RC from reset, no change before apply, then codes 2, 1 and 3 after apply.
  task automatic t_wdt();
    dw(`CPG_ADDR_WDT_RATIO, 32'h1);
    period(3, p);
    chk(p, 3, "watchdog on RC");
    dw(`CPG_ADDR_WDT_CHOICE, 32'h2);
    period(3, p);
    chk(p, 3, "watchdog before apply");
    ap(`CPG_GO_WDT_APPLY);
    dr(`CPG_ADDR_WDT_APPLY, v);
    chk(v, 32'h1, "watchdog apply bit");
    period(3, p);
    chk(p, 7, "watchdog on oscillator");
    dw(`CPG_ADDR_WDT_CHOICE, 32'h1);
    ap(`CPG_GO_WDT_APPLY);
    period(3, p);
    chk(p, 2, "watchdog on main");
    dw(`CPG_ADDR_WDT_CHOICE, 32'h3);
    ap(`CPG_GO_WDT_APPLY);
    period(3, p);
    chk(p, 0, "watchdog reserved code");
  endtask : t_wdt

  // Clock output: every code, checked before and after its apply.
  task automatic t_out();
    int op [4];
    op = '{3, 5, 7, 2};
    dw(`CPG_ADDR_OUT_RATIO, 32'h1);
    for (int c = 1; c <= 4; c++)
    begin
      dw(`CPG_ADDR_OUT_CHOICE, c % 4);
      period(4, p);
      chk(p, op[c - 1], "output before apply");
      ap(`CPG_GO_OUT_APPLY);
      period(4, p);
      chk(p, op[c % 4], "output after apply");
    end
  endtask : t_out

  // Apply waits while the sources are not both running.
  task automatic t_wait();
    @(posedge clk);
    bothSrcRunning <= 1'b0;
    dw(`CPG_ADDR_OUT_CHOICE, 32'h1);
    cw(`CPG_CTL_GO, 32'h1 << `CPG_GO_OUT_APPLY);
    repeat (10) @(posedge clk);
    cr(`CPG_CTL_STATUS, v);
    chk(v[`CPG_STAT_BUSY], 1'b1, "apply held");
    period(4, p);
    chk(p, 3, "output unchanged while held");
    @(posedge clk);
    bothSrcRunning <= 1'b1;
    idle();
    period(4, p);
    chk(p, 5, "output after release");
    dw(`CPG_ADDR_OUT_RATIO, 32'h0);
    period(4, p);
    chk(p, 0, "output ratio zero stops");
  endtask : t_wait

  // Free-running clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence.
  initial
  begin
    resetn = 1'b0;
    ctlAddr = 5'h00;
    ctlWdata = 32'h0;
    ctlWr = 1'b0;
    ctlRd = 1'b0;
    uartPinsReady = 1'b1;
    bothSrcRunning = 1'b1;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_gate();
    t_ratio();
    t_uart();
    t_wdt();
    t_out();
    t_wait();
    final_report();
  end
endmodule : tb_cpg
`default_nettype wire
